// ===== bench/cmf_bus_node.sv
// cmf_bus_node: the other nodes on the shared bus, wired-and with a pull-up
// assumes the bench commands dominant bits through dominant
module cmf_bus_node (
    input  wire logic can_tx,
    input  wire logic can_tx_oe,
    input  wire logic dominant,
    output wire logic can_rx
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // bus level: recessive unless some node drives dominant
    assign can_rx = ~((can_tx_oe & ~can_tx) | dominant);
endmodule : cmf_bus_node

// ===== bench/cmf_ctrl_test.sv
// cmf_ctrl_test: self-checking bench of cmf_ctrl
// assumes cmf_pkg, cmf_ctrl and cmf_bus_node are compiled first
module cmf_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // signals
    logic        core_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [4:0]  avs_address = '0, cfg_compare_len = '0, hit_num = '0, est = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, rdat;
    logic [3:0]  avs_byteenable = 4'h3, buf_irq_num = '0;
    logic        can_tx, can_tx_oe, can_pins_owned, engine_rx, module_halt, abort_all_tx;
    logic        accept_all, partial_copy, capture_evt, map_select, irq;
    logic        bit_tick = 0, engine_tx = 1, device_idle = 0, dominant = 0;
    logic [4:0]  data_compare_len;
    logic [11:0] ev = '0;
    wire         can_rx;
    logic        tx_bus_off, tx_bus_passive, rx_bus_passive, tx_err_warning, rx_err_warning;
    logic        ev_filter_hit, ev_proto_err, ev_rx_msg, ev_queue_write, ev_queue_read;
    logic        tx_all_aborted, ev_invalid, ev_wake, ev_overflow, ev_almost_full;
    logic        ev_rx_buf, ev_tx_buf;
    int          miscompares = 0, checks = 0;
    assign {tx_bus_off, tx_bus_passive, rx_bus_passive, tx_err_warning, rx_err_warning} = est;
    assign {ev_filter_hit, ev_proto_err, ev_rx_msg, ev_queue_write, ev_queue_read,
            tx_all_aborted, ev_invalid, ev_wake, ev_overflow, ev_almost_full,
            ev_rx_buf, ev_tx_buf} = ev;
    cmf_ctrl DUT (.*);
    cmf_bus_node peer (.*);
    always #5 core_clk = ~core_clk;
    // ==========================================
    // helpers
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= w;
        avs_read <= ~w;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic pl(input int b);
        @(posedge core_clk);
        ev[b] <= 1'b1;
        @(posedge core_clk);
        ev[b] <= 1'b0;
        @(negedge core_clk);
    endtask : pl
    task automatic mode(input logic [2:0] m);
        bus(1'b1, cmf_pkg::ADDR_MODE_CTRL, {5'h00, m, 8'h00});
        repeat (12) begin
            @(posedge core_clk);
            bit_tick <= 1'b1;
            @(posedge core_clk);
            bit_tick <= 1'b0;
        end
        bus(1'b0, cmf_pkg::ADDR_MODE_CTRL, 16'h0000);
    endtask : mode
    function automatic logic [4:0] exp_len(input logic [4:0] v);
        return (v > cmf_pkg::CMP_LEN_MAX) ? 5'h00 : v;
    endfunction : exp_len
    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // ==========================================
    // tests
    initial begin
        static logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
        static logic [4:0] h = '0;
        void'($urandom(25889));
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        bus(1'b0, cmf_pkg::ADDR_MODE_CTRL, 16'h0000);
        chk("mode_reg", 32'h0000_0480, rdat);
        bus(1'b0, 5'h1C, 16'h0000);
        chk("unmapped", 32'h0000_0000, rdat);
        dominant <= 1'b1;
        mode(3'h0);
        chk("busy_bus", 32'h0000_0080, rdat);
        dominant <= 1'b0;
        $display("test reset and busy bus done");
        foreach (modes[i]) begin
            mode(modes[i]);
            chk("mode", {16'h0000, 5'h00, modes[i], modes[i], 5'h00}, rdat);
            chk("owned", !(modes[i] inside {3'h1, 3'h2}), can_pins_owned);
            chk("accept_all", modes[i] == 3'h7, accept_all);
            engine_tx <= 1'($urandom);
            repeat (3) @(negedge core_clk);
            if (modes[i] == 3'h2) chk("loop", engine_tx, engine_rx);
            chk("oe", modes[i] == 3'h0, can_tx_oe);
            chk("tx", engine_tx, can_tx);
            if (modes[i] == 3'h7) pl(10);
            if (modes[i] == 3'h7) chk("partial", 1'b1, partial_copy);
            @(posedge core_clk);
            engine_tx <= 1'b1;
        end
        bus(1'b1, cmf_pkg::ADDR_MODE_CTRL, 16'h0500);
        bus(1'b0, cmf_pkg::ADDR_MODE_CTRL, 16'h0000);
        chk("rsvd_req", 32'h0000_0480, rdat);
        $display("test modes done");
        device_idle <= 1'b1;
        bus(1'b1, cmf_pkg::ADDR_MODE_CTRL, 16'h3409);
        repeat (2) @(negedge core_clk);
        chk("halt", 1'b1, module_halt);
        chk("abort", 1'b1, abort_all_tx);
        chk("map", 1'b1, map_select);
        @(posedge core_clk);
        device_idle <= 1'b0;
        pl(9);
        chk("capture", 1'b1, capture_evt);
        pl(6);
        chk("abort_clr", 1'b0, abort_all_tx);
        $display("test control bits done");
        bus(1'b1, cmf_pkg::ADDR_IRQ_EN, 16'h00EF);
        for (int k = 0; k < 3; k++) begin
            pl(4 - k);
            bus(1'b0, cmf_pkg::ADDR_IRQ_CODE, 16'h0000);
            chk("irq_source_code", 32'h0000_0042 + k, {25'h0, rdat[6:0]});
            chk("irq", 1'b1, irq);
            bus(1'b1, cmf_pkg::ADDR_IRQ_FLAGS, 16'h0000);
            @(negedge core_clk);
            chk("irq_clr", 1'b0, irq);
        end
        @(posedge core_clk);
        buf_irq_num <= 4'($urandom);
        pl(1);
        bus(1'b0, cmf_pkg::ADDR_IRQ_CODE, 16'h0000);
        chk("buf_code", {28'h0, buf_irq_num}, {25'h0, rdat[6:0]});
        bus(1'b1, cmf_pkg::ADDR_IRQ_FLAGS, 16'h0000);
        est <= 5'h02;
        bus(1'b0, cmf_pkg::ADDR_IRQ_CODE, 16'h0000);
        chk("err_code", 32'h0000_0041, {25'h0, rdat[6:0]});
        bus(1'b0, cmf_pkg::ADDR_IRQ_FLAGS, 16'h0000);
        chk("err_flags", 32'h0000_0520, rdat);
        bus(1'b1, cmf_pkg::ADDR_IRQ_EN, 16'h0000);
        pl(4);
        chk("masked", 1'b0, irq);
        bus(1'b0, cmf_pkg::ADDR_IRQ_FLAGS, 16'h0000);
        chk("wake_flag", 1'b1, rdat[6]);
        $display("test interrupts done");
        bus(1'b1, cmf_pkg::ADDR_BUF_AREA, 16'h0002);
        pl(8);
        pl(8);
        pl(7);
        bus(1'b0, cmf_pkg::ADDR_QUEUE_PTR, 16'h0000);
        chk("qptr", 32'h0000_0203, rdat);
        $display("test queue pointers done");
        for (int k = 0; k < 20; k++) begin
            cfg_compare_len <= 5'($urandom);
            hit_num <= 5'($urandom);
            est <= 5'($urandom);
            pl(11);
            if (hit_num <= cmf_pkg::HIT_MAX) h = hit_num;
            chk("cmp_out", exp_len(cfg_compare_len), data_compare_len);
            bus(1'b0, cmf_pkg::ADDR_FILT_LEN, 16'h0000);
            chk("cmp_len", exp_len(cfg_compare_len), rdat);
            bus(1'b0, cmf_pkg::ADDR_IRQ_CODE, 16'h0000);
            chk("hit", h, rdat[12:8]);
            bus(1'b0, cmf_pkg::ADDR_IRQ_FLAGS, 16'h0000);
            chk("err_state", {est, |est[1:0]}, rdat[13:8]);
        end
        $display("test random status done");
        final_report();
    end
    initial begin
        #100us;
        miscompares++;
        final_report();
    end
endmodule : cmf_ctrl_test

// ===== design/cmf_ctrl.sv
// cmf_ctrl: mode, pin routing, queue pointers, status and interrupt flags of a can controller
// assumes protocol engine inputs on core_clk; can_rx is a pin and is synchronised here
// Operation
// (R1) request code 111 enters a mode that ignores errors and accepts every message
// (R2) in that mode an error copies the partly assembled message to the receive buffer
// (R3) loopback feeds the internal transmit signal back as the internal receive signal
// (R4) loopback releases the bus transmit and receive pins to port use
// (R5) idle-stop set halts the module while the device idles; clear keeps it running
// (R6) setting abort-all tells every transmit buffer to abort
// (R7) hardware clears abort-all once all transmissions are aborted
// (R8) mode codes: normal, disable, loopback, listen, config, accept-all; 101/110 unused
// (R9) read-only mode status at bits 7:5 shows the mode actually entered
// (R10) capture-link set makes each received message pulse the timer capture event
// (R11) map select switches the shared address space: filters (1) or buffers (0)
// (R12) five-bit data compare length: 0 off, 10001 maximum, above invalid
// (R13) read-only number of the filter that matched the last message, 0 to 15
// (R14) seven-bit interrupt code names buffer 0-15, none, error, wake, overflow, almost full
// (R15) buffer-size code selects 4 to 32 message buffers; 111 reserved (code 111 is accepted here and gives 32, like 110)
// (R16) five-bit field sets the buffer where the receive queue begins
// (R17) read-only six-bit pointer of the next buffer the queue writes
// (R18) read-only six-bit pointer of the next buffer software reads
// (R19) read-only bits show bus-off, passive and warning states of transmitter and receiver
// (R20) combined warning bit is set when either side is in warning
// (R21) error flag is raised by the error-state bits of the flag register
// (R22) seven event flags are set by hardware and cleared by software writing zero
// (R23) each flag has an enable in the same bit position
// (R24) mode and status change only when the bus has idled 11 recessive bits
// (R25) interrupt output is high while any flag and its enable are both set
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
module cmf_ctrl (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        can_rx,
    output logic             can_tx,
    output logic             can_tx_oe,
    output logic             can_pins_owned,
    input  wire logic        bit_tick,
    input  wire logic        engine_tx,
    output logic             engine_rx,
    input  wire logic        device_idle,
    output logic             module_halt,
    output logic             abort_all_tx,
    input  wire logic        tx_all_aborted,
    output logic             accept_all,
    input  wire logic        ev_proto_err,
    output logic             partial_copy,
    input  wire logic        ev_rx_msg,
    output logic             capture_evt,
    output logic             map_select,
    input  wire logic [4:0]  cfg_compare_len,
    output logic      [4:0]  data_compare_len,
    input  wire logic        ev_filter_hit,
    input  wire logic [4:0]  hit_num,
    input  wire logic [3:0]  buf_irq_num,
    input  wire logic        ev_queue_write,
    input  wire logic        ev_queue_read,
    input  wire logic        tx_bus_off,
    input  wire logic        tx_bus_passive,
    input  wire logic        rx_bus_passive,
    input  wire logic        tx_err_warning,
    input  wire logic        rx_err_warning,
    input  wire logic        ev_invalid,
    input  wire logic        ev_wake,
    input  wire logic        ev_overflow,
    input  wire logic        ev_almost_full,
    input  wire logic        ev_rx_buf,
    input  wire logic        ev_tx_buf,
    output logic             irq
);
    // ==========================================================
    // state
    logic                  wait_q, wait_d;
    logic [31:0]           rdata_q, rdata_d;
    logic                  rx_meta_q, rx_sync_q;
    cmf_pkg::cmf_mode_type mode_q, mode_d;
    logic [2:0]            req_q, req_d;
    logic [3:0]            idle_cnt_q, idle_cnt_d;
    logic                  tx_q, tx_d, oe_q, oe_d, own_q, own_d, erx_q, erx_d;
    logic                  idle_stop_q, idle_stop_d, halt_q, halt_d;
    logic                  abort_q, abort_d, cap_q, cap_d, map_q, map_d;
    logic                  acc_q, acc_d, pcopy_q, pcopy_d, capev_q, capev_d;
    logic [4:0]            cmp_q, cmp_d, hit_q, hit_d, fsa_q, fsa_d;
    logic [2:0]            dma_q, dma_d;
    logic [5:0]            wptr_q, wptr_d, rptr_q, rptr_d, nbuf;
    logic [5:0]            err_q, err_d;
    logic [7:0]            flags_q, flags_d, en_q, en_d, fset;
    logic                  irq_q, irq_d;
    logic                  wr_en, abort_set, line;
    logic [15:0]           wmask, cur, wval;
    logic [6:0]            irq_source_code;
    logic [7:0]            pend;

    // ==========================================================
    // avalon slave: one wait cycle, effect at the edge waitrequest is low
    always_comb begin
        wr_en    = avs_write & ~wait_q;
        wait_d   = ~((avs_read | avs_write) & wait_q);
        wmask    = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        pend     = flags_q & en_q;
        if (pend[cmf_pkg::FLG_ERROR]) begin //(R14)
            irq_source_code = cmf_pkg::IRQ_SOURCE_CODE_ERR;
        end else if (pend[cmf_pkg::FLG_WAKE]) begin
            irq_source_code = cmf_pkg::IRQ_SOURCE_CODE_WAKE;
        end else if (pend[cmf_pkg::FLG_OVF]) begin
            irq_source_code = cmf_pkg::IRQ_SOURCE_CODE_OVF;
        end else if (pend[cmf_pkg::FLG_AFULL]) begin
            irq_source_code = cmf_pkg::IRQ_SOURCE_CODE_AFULL;
        end else if (pend[cmf_pkg::FLG_RXBUF] | pend[cmf_pkg::FLG_TXBUF]) begin
            irq_source_code = {3'h0, buf_irq_num};
        end else begin
            irq_source_code = cmf_pkg::IRQ_SOURCE_CODE_NONE;
        end
        case (avs_address)
            cmf_pkg::ADDR_MODE_CTRL: cur = {2'h0, idle_stop_q, abort_q, 1'h0, req_q,
                                            mode_q, 1'h0, cap_q, 2'h0, map_q}; //(R9)
            cmf_pkg::ADDR_FILT_LEN:  cur = {11'h000, cmp_q};
            cmf_pkg::ADDR_IRQ_CODE:  cur = {3'h0, hit_q, 1'h0, irq_source_code}; //(R13)
            cmf_pkg::ADDR_BUF_AREA:  cur = {dma_q, 8'h00, fsa_q};
            cmf_pkg::ADDR_QUEUE_PTR: cur = {2'h0, wptr_q, 2'h0, rptr_q}; //(R17) (R18)
            cmf_pkg::ADDR_IRQ_FLAGS: cur = {2'h0, err_q, flags_q}; //(R19)
            cmf_pkg::ADDR_IRQ_EN:    cur = {8'h00, en_q};
            default:                 cur = 16'h0000;
        endcase
        wval    = (cur & ~wmask) | (avs_writedata[15:0] & wmask);
        rdata_d = rdata_q;
        if (avs_read & wait_q) begin
            rdata_d = {16'h0000, cur};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // mode, pin routing, bus idle detection
    always_comb begin
        req_d = req_q;
        if (wr_en && avs_address == cmf_pkg::ADDR_MODE_CTRL
                && wval[cmf_pkg::REQ_LSB+:3] != cmf_pkg::MODE_RSVD_A
                && wval[cmf_pkg::REQ_LSB+:3] != cmf_pkg::MODE_RSVD_B) begin //(R8)
            req_d = wval[cmf_pkg::REQ_LSB+:3];
        end
        mode_d = mode_q;
        if (idle_cnt_q == cmf_pkg::IDLE_BITS) begin //(R24)
            mode_d = cmf_pkg::cmf_mode_type'(req_q);
        end
        own_d = (mode_q != cmf_pkg::MODE_LOOPBACK) && (mode_q != cmf_pkg::MODE_DISABLE); //(R4)
        oe_d  = mode_q == cmf_pkg::MODE_NORMAL;
        tx_d  = engine_tx;
        if (mode_q == cmf_pkg::MODE_LOOPBACK) begin
            line = engine_tx; //(R3)
        end else if (own_q) begin
            line = rx_sync_q;
        end else begin
            line = 1'b1;
        end
        erx_d      = line;
        idle_cnt_d = idle_cnt_q;
        if (!line) begin
            idle_cnt_d = 4'h0;
        end else if (bit_tick && idle_cnt_q != cmf_pkg::IDLE_BITS) begin
            idle_cnt_d = 4'(idle_cnt_q + 4'h1);
        end
        acc_d   = mode_q == cmf_pkg::MODE_LISTEN_ALL; //(R1)
        pcopy_d = (mode_q == cmf_pkg::MODE_LISTEN_ALL) & ev_proto_err; //(R2)
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_meta_q  <= 1'b1;
            rx_sync_q  <= 1'b1;
            req_q      <= cmf_pkg::MODE_CONFIG;
            mode_q     <= cmf_pkg::MODE_CONFIG;
            idle_cnt_q <= 4'h0;
            own_q      <= 1'b1;
            oe_q       <= 1'b0;
            tx_q       <= 1'b1;
            erx_q      <= 1'b1;
            acc_q      <= 1'b0;
            pcopy_q    <= 1'b0;
        end else begin
            rx_meta_q  <= can_rx;
            rx_sync_q  <= rx_meta_q;
            req_q      <= req_d;
            mode_q     <= mode_d;
            idle_cnt_q <= idle_cnt_d;
            own_q      <= own_d;
            oe_q       <= oe_d;
            tx_q       <= tx_d;
            erx_q      <= erx_d;
            acc_q      <= acc_d;
            pcopy_q    <= pcopy_d;
        end
    end

    // ==========================================================
    // control fields and queue pointers
    always_comb begin
        idle_stop_d = idle_stop_q;
        cap_d       = cap_q;
        map_d       = map_q;
        dma_d       = dma_q;
        fsa_d       = fsa_q;
        abort_set   = 1'b0;
        if (wr_en && avs_address == cmf_pkg::ADDR_MODE_CTRL) begin
            idle_stop_d = wval[cmf_pkg::IDLE_STOP_BIT];
            cap_d       = wval[cmf_pkg::CAP_BIT];
            map_d       = wval[cmf_pkg::MAP_BIT]; //(R11)
            abort_set   = wval[cmf_pkg::ABORT_BIT]; //(R6)
        end
        if (wr_en && avs_address == cmf_pkg::ADDR_BUF_AREA) begin
            dma_d = wval[cmf_pkg::DMA_LSB+:3]; //(R15)
            fsa_d = wval[4:0]; //(R16)
        end
        if (abort_set) begin
            abort_d = 1'b1;
        end else if (tx_all_aborted) begin
            abort_d = 1'b0; //(R7)
        end else begin
            abort_d = abort_q;
        end
        halt_d  = idle_stop_q & device_idle; //(R5)
        capev_d = cap_q & ev_rx_msg; //(R10)
        cmp_d   = (cfg_compare_len > cmf_pkg::CMP_LEN_MAX) ? 5'h00 : cfg_compare_len; //(R12)
        hit_d   = hit_q;
        if (ev_filter_hit && hit_num <= cmf_pkg::HIT_MAX) begin
            hit_d = hit_num; //(R13)
        end
        nbuf   = cmf_pkg::buf_count(dma_q);
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        if (wr_en && avs_address == cmf_pkg::ADDR_BUF_AREA) begin
            wptr_d = {1'b0, wval[4:0]};
            rptr_d = {1'b0, wval[4:0]};
        end else begin
            if (ev_queue_write) begin //(R17)
                wptr_d = (6'(wptr_q + 6'h01) >= nbuf) ? {1'b0, fsa_q} : 6'(wptr_q + 6'h01);
            end
            if (ev_queue_read) begin //(R18)
                rptr_d = (6'(rptr_q + 6'h01) >= nbuf) ? {1'b0, fsa_q} : 6'(rptr_q + 6'h01);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            idle_stop_q <= 1'b0;
            cap_q       <= 1'b0;
            map_q       <= 1'b0;
            abort_q     <= 1'b0;
            dma_q       <= 3'h0;
            fsa_q       <= 5'h00;
            halt_q      <= 1'b0;
            capev_q     <= 1'b0;
            cmp_q       <= 5'h00;
            hit_q       <= 5'h00;
            wptr_q      <= 6'h00;
            rptr_q      <= 6'h00;
        end else begin
            idle_stop_q <= idle_stop_d;
            cap_q       <= cap_d;
            map_q       <= map_d;
            abort_q     <= abort_d;
            dma_q       <= dma_d;
            fsa_q       <= fsa_d;
            halt_q      <= halt_d;
            capev_q     <= capev_d;
            cmp_q       <= cmp_d;
            hit_q       <= hit_d;
            wptr_q      <= wptr_d;
            rptr_q      <= rptr_d;
        end
    end

    // ==========================================================
    // error state, flags, enables, interrupt
    always_comb begin
        err_d = {tx_bus_off, tx_bus_passive, rx_bus_passive, tx_err_warning,
                 rx_err_warning, tx_err_warning | rx_err_warning}; //(R19) (R20)
        fset                    = 8'h00;
        fset[cmf_pkg::FLG_INVALID] = ev_invalid;
        fset[cmf_pkg::FLG_WAKE]    = ev_wake;
        fset[cmf_pkg::FLG_ERROR]   = |(err_d & ~err_q); //(R21)
        fset[cmf_pkg::FLG_AFULL]   = ev_almost_full;
        fset[cmf_pkg::FLG_OVF]     = ev_overflow;
        fset[cmf_pkg::FLG_RXBUF]   = ev_rx_buf;
        fset[cmf_pkg::FLG_TXBUF]   = ev_tx_buf;
        flags_d = flags_q;
        en_d    = en_q;
        if (wr_en && avs_address == cmf_pkg::ADDR_IRQ_FLAGS) begin
            flags_d = flags_q & ~(wmask[7:0] & ~avs_writedata[7:0]); //(R22)
        end
        if (wr_en && avs_address == cmf_pkg::ADDR_IRQ_EN) begin
            en_d = wval[7:0] & cmf_pkg::FLAG_MASK; //(R23)
        end
        flags_d = (flags_d | fset) & cmf_pkg::FLAG_MASK; //(R22)
        irq_d   = |(flags_d & en_d); //(R25)
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            err_q   <= 6'h00;
            flags_q <= 8'h00;
            en_q    <= 8'h00;
            irq_q   <= 1'b0;
        end else begin
            err_q   <= err_d;
            flags_q <= flags_d;
            en_q    <= en_d;
            irq_q   <= irq_d;
        end
    end

    // ==========================================================
    // outputs
    assign avs_readdata     = rdata_q;
    assign avs_waitrequest  = wait_q;
    assign can_tx           = tx_q;
    assign can_tx_oe        = oe_q;
    assign can_pins_owned   = own_q;
    assign engine_rx        = erx_q;
    assign module_halt      = halt_q;
    assign abort_all_tx     = abort_q;
    assign accept_all       = acc_q;
    assign partial_copy     = pcopy_q;
    assign capture_evt      = capev_q;
    assign map_select       = map_q;
    assign data_compare_len = cmp_q;
    assign irq              = irq_q;

    // ==========================================================
    // checks
    property p_mode_idle;
        @(posedge core_clk) disable iff (!rst_n)
        (mode_q != $past(mode_q)) |-> ($past(idle_cnt_q) == cmf_pkg::IDLE_BITS);
    endproperty
    a_mode_idle: assert property (p_mode_idle) else $error("mode changed without idle bus"); //(R24)
    property p_accept_all;
        @(posedge core_clk) disable iff (!rst_n)
        (mode_q == cmf_pkg::MODE_LISTEN_ALL && ev_proto_err) |=> partial_copy && accept_all;
    endproperty
    a_accept_all: assert property (p_accept_all) else $error("no partial copy on error"); //(R2)
    property p_loop;
        @(posedge core_clk) disable iff (!rst_n)
        (mode_q == cmf_pkg::MODE_LOOPBACK) |=> (engine_rx == $past(engine_tx));
    endproperty
    a_loop: assert property (p_loop) else $error("loopback path broken"); //(R3)
    property p_release;
        @(posedge core_clk) disable iff (!rst_n)
        (mode_q == cmf_pkg::MODE_LOOPBACK) [*2] |-> !can_pins_owned && !can_tx_oe;
    endproperty
    a_release: assert property (p_release) else $error("pins held in loopback"); //(R4)
    property p_abort_clear;
        @(posedge core_clk) disable iff (!rst_n)
        (abort_q && tx_all_aborted && !abort_set) |=> !abort_all_tx;
    endproperty
    a_abort_clear: assert property (p_abort_clear) else $error("abort not cleared"); //(R7)
    property p_capture;
        @(posedge core_clk) disable iff (!rst_n)
        ev_rx_msg |=> (capture_evt == $past(cap_q));
    endproperty
    a_capture: assert property (p_capture) else $error("capture event wrong"); //(R10)
    property p_warn;
        @(posedge core_clk) disable iff (!rst_n)
        err_q[0] == (err_q[1] | err_q[2]);
    endproperty
    a_warn: assert property (p_warn) else $error("combined warning wrong"); //(R20)
    property p_err_flag;
        @(posedge core_clk) disable iff (!rst_n)
        (tx_bus_off && !err_q[5]) |=> flags_q[cmf_pkg::FLG_ERROR];
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("error flag not raised"); //(R21)
    property p_irq;
        @(posedge core_clk) disable iff (!rst_n)
        irq == (|(flags_q & en_q));
    endproperty
    a_irq: assert property (p_irq) else $error("irq disagrees with flags"); //(R25)
    property p_cmp_len;
        @(posedge core_clk) disable iff (!rst_n)
        (cfg_compare_len > cmf_pkg::CMP_LEN_MAX) |=> (data_compare_len == 5'h00);
    endproperty
    a_cmp_len: assert property (p_cmp_len) else $error("invalid compare length kept"); //(R12)
endmodule : cmf_ctrl

// ===== design/cmf_pkg.sv
// cmf_pkg: register map, field layout, codes and constants of the mode and irq control block
// assumes a 16-bit register file behind a 32-bit avalon-mm slave, one word per register
package cmf_pkg;
    // ==========================================================
    // register byte addresses
    localparam logic [4:0] ADDR_MODE_CTRL  = 5'h00;
    localparam logic [4:0] ADDR_FILT_LEN   = 5'h04;
    localparam logic [4:0] ADDR_IRQ_CODE   = 5'h08;
    localparam logic [4:0] ADDR_BUF_AREA   = 5'h0C;
    localparam logic [4:0] ADDR_QUEUE_PTR  = 5'h10;
    localparam logic [4:0] ADDR_IRQ_FLAGS  = 5'h14;
    localparam logic [4:0] ADDR_IRQ_EN     = 5'h18;
    // ==========================================================
    // field positions
    localparam int IDLE_STOP_BIT = 13;
    localparam int ABORT_BIT     = 12;
    localparam int REQ_LSB       = 8;
    localparam int STAT_LSB      = 5;
    localparam int CAP_BIT       = 3;
    localparam int MAP_BIT       = 0;
    localparam int HIT_LSB       = 8;
    localparam int DMA_LSB       = 13;
    localparam int WPTR_LSB      = 8;
    localparam int ERR_LSB       = 8;
    localparam int FLG_INVALID   = 7;
    localparam int FLG_WAKE      = 6;
    localparam int FLG_ERROR     = 5;
    localparam int FLG_AFULL     = 3;
    localparam int FLG_OVF       = 2;
    localparam int FLG_RXBUF     = 1;
    localparam int FLG_TXBUF     = 0;
    localparam logic [7:0] FLAG_MASK = 8'hEF;
    // ==========================================================
    // operating modes
    typedef enum logic [2:0] {
        MODE_NORMAL     = 3'b000,
        MODE_DISABLE    = 3'b001,
        MODE_LOOPBACK   = 3'b010,
        MODE_LISTEN     = 3'b011,
        MODE_CONFIG     = 3'b100,
        MODE_LISTEN_ALL = 3'b111
    } cmf_mode_type;
    localparam logic [2:0] MODE_RSVD_A = 3'b101;
    localparam logic [2:0] MODE_RSVD_B = 3'b110;
    // ==========================================================
    // interrupt source codes and limits
    localparam logic [6:0] IRQ_SOURCE_CODE_NONE  = 7'h40;
    localparam logic [6:0] IRQ_SOURCE_CODE_ERR   = 7'h41;
    localparam logic [6:0] IRQ_SOURCE_CODE_WAKE  = 7'h42;
    localparam logic [6:0] IRQ_SOURCE_CODE_OVF   = 7'h43;
    localparam logic [6:0] IRQ_SOURCE_CODE_AFULL = 7'h44;
    localparam logic [4:0] CMP_LEN_MAX = 5'h11;
    localparam logic [4:0] HIT_MAX     = 5'h0F;
    localparam logic [3:0] IDLE_BITS   = 4'hB;
    // ==========================================================
    // message buffer count per buffer-size code
    function automatic logic [5:0] buf_count(input logic [2:0] code);
        case (code)
            3'h0:    buf_count = 6'h04;
            3'h1:    buf_count = 6'h06;
            3'h2:    buf_count = 6'h08;
            3'h3:    buf_count = 6'h0C;
            3'h4:    buf_count = 6'h10;
            3'h5:    buf_count = 6'h18;
            default: buf_count = 6'h20;
        endcase
    endfunction : buf_count
endpackage : cmf_pkg
